//--- core/fpx_defs.svh
`ifndef FPX_DEFS_SVH
`define FPX_DEFS_SVH
// Exception flag and mask bit positions
`define FPX_IE 0
`define FPX_DE 1
`define FPX_ZE 2
`define FPX_OE 3
`define FPX_UFLOW 4
`define FPX_PREC 5
`define FPX_SIMD_MASK_LSB 7
// Register offsets
`define FPX_OFF_STK_STATUS 12'h000
`define FPX_OFF_STK_CTRL 12'h004
`define FPX_OFF_SIMD_CSR 12'h008
`define FPX_OFF_RESULT 12'h00C
// Reset values: all exceptions masked, flags clear
`define FPX_RST_STK_CTRL 32'h0000003F
`define FPX_RST_SIMD_CSR 32'h00001F80
// Smallest normal exponents, unbiased
`define FPX_EMIN_SGL (-126)
`define FPX_EMIN_DBL (-1022)
`define FPX_EMIN_EXT (-16382)
`endif

//--- core/fpx_pkg.sv
package fpx_pkg;
	typedef enum logic [1:0] {FMT_SGL = 2'h0, FMT_DBL = 2'h1,
		FMT_EXT = 2'h2} fpx_fmt_e;
	typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_EVAL = 3'b010,
		ST_DONE = 3'b100} fpx_state_e;
	// Operation report from the datapath
	typedef struct packed {
		logic simd;
		logic mem_dst;
		fpx_fmt_e fmt;
		logic stk_under;
		logic stk_over;
		logic unsup;
		logic snan;
		logic qnan;
		logic inv_other;
		logic div_zero;
		logic denorm;
		logic signed [17:0] rexp;
		logic inexact;
		logic overflow;
	} fpx_op_s;
	// Verdict to the datapath
	typedef struct packed {
		logic [5:0] raised;
		logic write_dst;
		logic biased;
		logic qnan_result;
		logic denorm_result;
		logic handler;
		logic clr_cond1;
	} fpx_res_s;
endpackage

//--- core/fpx_exc.sv
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "fpx_defs.svh"
module fpx_exc
	import fpx_pkg::*;
(
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_B,
	// Datapath operation report
	input wire logic I_OP_VALID,
	input wire fpx_op_s I_OP,
	// Verdict and stack condition bit
	output fpx_res_s O_RES,
	output logic O_RES_VALID,
	output logic O_COND1_CLR,
	// AXI4-Lite write channels
	input wire logic [11:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	// AXI4-Lite read channels
	input wire logic [11:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY
);

	//--------------------------------------------------
	// Mask selection and tiny detection
	//--------------------------------------------------
	fpx_state_e state_q, state_d;
	fpx_op_s op_q;
	logic [31:0] stk_stat_q, stk_ctrl_q, simd_csr_q;
	fpx_res_s res_q;
	logic cond1_q;
	wire [5:0] msk;
	wire [5:0] pre_set, post_set;
	wire tiny, pre_hit, pre_unm, ou_any, ou_unm, uflow_raise, oe_raise;
	wire prec_raise, post_unm, qnan_win, inv_hi, inv_lo;

	// Emin for a format; used for the tiny check only
	function automatic logic signed [17:0] emin(input fpx_fmt_e f);
		case (f)
			FMT_SGL: emin = 18'(`FPX_EMIN_SGL);
			FMT_DBL: emin = 18'(`FPX_EMIN_DBL);
			default: emin = 18'(`FPX_EMIN_EXT);
		endcase
	endfunction

	assign msk = op_q.simd ? simd_csr_q[`FPX_SIMD_MASK_LSB +: 6]
		: stk_ctrl_q[5:0];
	// Rounded exponent from datapath already honours precision control
	assign tiny = op_q.rexp < emin(op_q.fmt);

	//--------------------------------------------------
	// Precedence tree
	//--------------------------------------------------
	// Pre-operation conditions resolved before any result exists
	assign inv_hi = op_q.stk_under | op_q.stk_over | op_q.unsup
		| op_q.snan;
	assign qnan_win = !inv_hi & op_q.qnan;
	assign inv_lo = !inv_hi & !qnan_win & op_q.inv_other;
	assign pre_set[`FPX_IE] = inv_hi | inv_lo;
	assign pre_set[`FPX_ZE] = !inv_hi & !qnan_win & !op_q.inv_other
		& op_q.div_zero;
	assign pre_set[`FPX_DE] = !inv_hi & !qnan_win & !op_q.inv_other
		& !op_q.div_zero & op_q.denorm;
	assign pre_set[`FPX_OE] = 1'b0;
	assign pre_set[`FPX_UFLOW] = 1'b0;
	assign pre_set[`FPX_PREC] = 1'b0;
	assign pre_hit = pre_set[`FPX_IE] | pre_set[`FPX_ZE] | qnan_win;
	assign pre_unm = |(pre_set & ~msk);
	// Post-operation only after masked denormal or no pre fault
	assign oe_raise = op_q.overflow & !pre_hit & !pre_unm;
	assign uflow_raise = !pre_hit & !pre_unm & !op_q.overflow & tiny
		& (!msk[`FPX_UFLOW] | op_q.inexact);
	assign ou_any = oe_raise | uflow_raise;
	assign ou_unm = (oe_raise & !msk[`FPX_OE])
		| (uflow_raise & !msk[`FPX_UFLOW]);
	// Memory store with unmasked over/underflow hides inexact
	assign prec_raise = !pre_hit & !pre_unm & op_q.inexact
		& !(ou_unm & op_q.mem_dst);
	assign post_set = {prec_raise, uflow_raise, oe_raise, 3'b000};
	assign post_unm = ou_unm
		| (prec_raise & !msk[`FPX_PREC]);

	//--------------------------------------------------
	// Sequencer
	//--------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: if (I_OP_VALID) state_d = ST_EVAL;
			ST_EVAL: state_d = ST_DONE;
			ST_DONE: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	// Capture report, evaluate one cycle later
	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_B)
		begin
			state_q <= ST_IDLE;
			op_q <= '0;
			res_q <= '0;
			cond1_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			if (state_q == ST_IDLE && I_OP_VALID)
				op_q <= I_OP;
			cond1_q <= 1'b0;
			if (state_q == ST_EVAL)
			begin
				res_q.raised <= pre_set | post_set;
				// No write on unmasked pre fault; SIMD none on unmasked post fault
				res_q.write_dst <= !pre_unm
					& !(post_unm & op_q.simd);
				res_q.biased <= ou_unm & !op_q.simd;
				res_q.qnan_result <= qnan_win
					| (pre_set[`FPX_IE] & msk[`FPX_IE]);
				res_q.denorm_result <= tiny & !op_q.overflow
					& msk[`FPX_UFLOW] & !pre_hit;
				res_q.handler <= pre_unm | post_unm;
				res_q.clr_cond1 <= ou_unm & op_q.mem_dst;
				cond1_q <= ou_unm & op_q.mem_dst & !op_q.simd;
			end
		end
	end

	assign O_RES = res_q;
	assign O_RES_VALID = (state_q == ST_DONE);
	assign O_COND1_CLR = cond1_q;

	//--------------------------------------------------
	// AXI4-Lite slave
	//--------------------------------------------------
	logic aw_q, w_q, bv_q, rv_q;
	logic [11:0] awa_q;
	logic [31:0] wd_q, rd_q;
	logic [3:0] ws_q;
	logic [1:0] rr_q, br_q;
	wire wr_go, rd_go, wr_map, rd_map;
	wire [31:0] wmask, rd_mux;
	wire [5:0] new_flags;

	assign wr_go = aw_q & w_q & !bv_q;
	assign rd_go = I_ARVALID & !rv_q;
	assign wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}},
		{8{ws_q[0]}}};
	assign wr_map = awa_q == `FPX_OFF_STK_STATUS
		|| awa_q == `FPX_OFF_STK_CTRL || awa_q == `FPX_OFF_SIMD_CSR;
	assign rd_map = I_ARADDR == `FPX_OFF_STK_STATUS
		|| I_ARADDR == `FPX_OFF_STK_CTRL
		|| I_ARADDR == `FPX_OFF_SIMD_CSR
		|| I_ARADDR == `FPX_OFF_RESULT;
	assign rd_mux = I_ARADDR == `FPX_OFF_STK_STATUS ? stk_stat_q
		: I_ARADDR == `FPX_OFF_STK_CTRL ? stk_ctrl_q
		: I_ARADDR == `FPX_OFF_SIMD_CSR ? simd_csr_q
		: I_ARADDR == `FPX_OFF_RESULT ? 32'(res_q) : 32'h00000000;
	assign new_flags = (state_q == ST_EVAL) ? (pre_set | post_set)
		: 6'h00;
	assign O_AWREADY = !aw_q;
	assign O_WREADY = !w_q;
	assign O_ARREADY = !rv_q;
	assign O_BVALID = bv_q;
	assign O_BRESP = br_q;
	assign O_RVALID = rv_q;
	assign O_RDATA = rd_q;
	assign O_RRESP = rr_q;

	// Address/data latches and responses
	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_B)
		begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			bv_q <= 1'b0;
			rv_q <= 1'b0;
			awa_q <= 12'h000;
			wd_q <= 32'h00000000;
			ws_q <= 4'h0;
			rd_q <= 32'h00000000;
			rr_q <= 2'h0;
			br_q <= 2'h0;
		end
		else
		begin
			if (I_AWVALID && !aw_q)
			begin
				aw_q <= 1'b1;
				awa_q <= I_AWADDR;
			end
			if (I_WVALID && !w_q)
			begin
				w_q <= 1'b1;
				wd_q <= I_WDATA;
				ws_q <= I_WSTRB;
			end
			if (wr_go)
			begin
				bv_q <= 1'b1;
				br_q <= wr_map ? 2'h0 : 2'h2;
			end
			if (bv_q && I_BREADY)
			begin
				bv_q <= 1'b0;
				aw_q <= 1'b0;
				w_q <= 1'b0;
			end
			if (rd_go)
			begin
				rv_q <= 1'b1;
				rd_q <= rd_mux;
				rr_q <= rd_map ? 2'h0 : 2'h2;
			end
			else if (rv_q && I_RREADY)
				rv_q <= 1'b0;
		end
	end

	// Control and sticky status; a new flag wins over a clear
	always_ff @(posedge I_CLK)
	begin
		if (!I_RST_B)
		begin
			stk_stat_q <= 32'h00000000;
			stk_ctrl_q <= `FPX_RST_STK_CTRL;
			simd_csr_q <= `FPX_RST_SIMD_CSR;
		end
		else
		begin
			if (wr_go && awa_q == `FPX_OFF_STK_STATUS)
				stk_stat_q[5:0] <= (stk_stat_q[5:0] & ~wmask[5:0])
					| (wd_q[5:0] & wmask[5:0]);
			if (wr_go && awa_q == `FPX_OFF_STK_CTRL)
				stk_ctrl_q[5:0] <= (stk_ctrl_q[5:0] & ~wmask[5:0])
					| (wd_q[5:0] & wmask[5:0]);
			if (wr_go && awa_q == `FPX_OFF_SIMD_CSR)
				simd_csr_q[12:0] <= (simd_csr_q[12:0] & ~wmask[12:0])
					| (wd_q[12:0] & wmask[12:0] & 13'h1FBF);
			if (!op_q.simd)
				stk_stat_q[5:0] <= ((wr_go
					&& awa_q == `FPX_OFF_STK_STATUS)
					? ((stk_stat_q[5:0] & ~wmask[5:0])
					| (wd_q[5:0] & wmask[5:0]))
					: stk_stat_q[5:0]) | new_flags;
			else
				simd_csr_q[5:0] <= ((wr_go && awa_q == `FPX_OFF_SIMD_CSR)
					? ((simd_csr_q[5:0] & ~wmask[5:0])
					| (wd_q[5:0] & wmask[5:0]))
					: simd_csr_q[5:0]) | new_flags;
		end
	end

	//--------------------------------------------------
	// Checks
	//--------------------------------------------------
	property p_tiny_exact;
		@(posedge I_CLK) disable iff (!I_RST_B)
		(state_q == ST_EVAL && msk[`FPX_UFLOW] && tiny && !op_q.inexact)
		|=> !O_RES.raised[`FPX_UFLOW];
	endproperty
	a_tiny_exact: assert property (p_tiny_exact)
		else $error("masked exact tiny raised underflow");
	property p_pre_nowrite;
		@(posedge I_CLK) disable iff (!I_RST_B)
		(state_q == ST_EVAL && pre_unm) |=> !O_RES.write_dst
		&& O_RES.handler;
	endproperty
	a_pre_nowrite: assert property (p_pre_nowrite)
		else $error("destination written on pre fault");
	property p_qnan_zero;
		@(posedge I_CLK) disable iff (!I_RST_B)
		(state_q == ST_EVAL && qnan_win) |=> !O_RES.raised[`FPX_ZE];
	endproperty
	a_qnan_zero: assert property (p_qnan_zero)
		else $error("divide by zero raised over quiet NaN");
	property p_mem_inexact;
		@(posedge I_CLK) disable iff (!I_RST_B)
		(state_q == ST_EVAL && ou_unm && op_q.mem_dst)
		|=> !O_RES.raised[`FPX_PREC] && O_RES.clr_cond1;
	endproperty
	a_mem_inexact: assert property (p_mem_inexact)
		else $error("inexact reported on unmasked store fault");
	property p_sticky;
		@(posedge I_CLK) disable iff (!I_RST_B)
		(stk_stat_q[`FPX_PREC] && !(wr_go && awa_q == `FPX_OFF_STK_STATUS))
		|=> stk_stat_q[`FPX_PREC];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("sticky flag dropped");
	property p_valid_two;
		@(posedge I_CLK) disable iff (!I_RST_B)
		(state_q == ST_IDLE && I_OP_VALID) |=> !O_RES_VALID ##1 O_RES_VALID;
	endproperty
	a_valid_two: assert property (p_valid_two)
		else $error("verdict timing wrong");
	property p_simd_post;
		@(posedge I_CLK) disable iff (!I_RST_B)
		(state_q == ST_EVAL && op_q.simd && ou_unm) |=> !O_RES.write_dst;
	endproperty
	a_simd_post: assert property (p_simd_post)
		else $error("SIMD destination written on post fault");
	property p_inv_wins;
		@(posedge I_CLK) disable iff (!I_RST_B)
		(state_q == ST_EVAL && op_q.snan && op_q.div_zero)
		|=> O_RES.raised[`FPX_IE] && !O_RES.raised[`FPX_ZE];
	endproperty
	a_inv_wins: assert property (p_inv_wins)
		else $error("lower exception not suppressed");
	property p_ou_inexact;
		@(posedge I_CLK) disable iff (!I_RST_B)
		(state_q == ST_EVAL && ou_any && op_q.inexact
		&& !(ou_unm && op_q.mem_dst)) |=> O_RES.raised[`FPX_PREC];
	endproperty
	a_ou_inexact: assert property (p_ou_inexact)
		else $error("inexact lost beside over or underflow");
endmodule

//--- dv/fpx_dp_model.sv
`timescale 1ns/1ps
// Datapath stand-in: one report a request
module fpx_dp_model
	import fpx_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Request from the bench
	input wire logic i_go,
	input wire fpx_op_s i_op,
	// Report to the exception block
	output logic o_valid,
	output fpx_op_s o_op
);
	// Idle data flips each cycle, so a stale report is never trusted
	always_ff @(posedge i_clk)
	begin
		o_valid <= i_go && i_rst_b;
		o_op <= !i_rst_b ? '0 : i_go ? i_op : ~o_op;
	end
endmodule

//--- dv/tb.sv
`timescale 1ns/1ps
`include "fpx_defs.svh"
module tb
	import fpx_pkg::*;
;
	// ----
	// Wiring
	// ----
	logic clk = 0, rst_b = 0, go = 0, opv, resv, cond1_clr;
	fpx_op_s op_in = '0, op;
	fpx_res_s res;
	logic [11:0] awa = '0, ara = '0;
	logic [31:0] wd = '0, rd;
	logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic awr, wr, bv, arr, rv;
	logic [1:0] br, rr;
	fpx_res_s qr[$];
	logic [11:0] qc[$];
	logic [5:0] msk[2], acc[2];
	int err_count = 0, comparisons = 0, seed = 90;
	always #20 clk = ~clk;
	fpx_dp_model u_fpx_dp_model (.i_clk(clk), .i_rst_b(rst_b), .i_go(go),
		.i_op(op_in), .o_valid(opv), .o_op(op));
	fpx_exc u_fpx_exc (.I_CLK(clk), .I_RST_B(rst_b), .I_OP_VALID(opv),
		.I_OP(op), .O_RES(res), .O_RES_VALID(resv),
		.O_COND1_CLR(cond1_clr),
		.I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd),
		.I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wr), .O_BRESP(br),
		.O_BVALID(bv), .I_BREADY(bry), .I_ARADDR(ara), .I_ARVALID(arv),
		.O_ARREADY(arr), .O_RDATA(rd), .O_RRESP(rr), .O_RVALID(rv),
		.I_RREADY(rry));
	// ----
	// Tasks
	// ----
	task automatic check(input string nm, input logic [31:0] s, e);
		comparisons++;
		if (s !== e)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Address and data offered together, each dropped once taken
	task automatic axw(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		bit ga, gw;
		ga = 0;
		gw = 0;
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bry <= 1;
		while (!(ga && gw))
		begin
			@(posedge clk);
			if (awr === 1'b1) awv <= 0;
			if (wr === 1'b1) wv <= 0;
			ga = ga || awr === 1'b1;
			gw = gw || wr === 1'b1;
		end
		while (bv !== 1'b1) @(posedge clk);
		check("bresp", 32'(br), 32'(er));
		bry <= 0;
		@(posedge clk);
	endtask
	task automatic axr(input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		ara <= a;
		arv <= 1;
		rry <= 1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 0;
		while (rv !== 1'b1) @(posedge clk);
		check("rdata", rd, ed);
		check("rresp", 32'(rr), 32'(er));
		rry <= 0;
		@(posedge clk);
	endtask
	function automatic int emin(input fpx_fmt_e f);
		return f == FMT_SGL ? `FPX_EMIN_SGL : f == FMT_DBL ? `FPX_EMIN_DBL
			: `FPX_EMIN_EXT;
	endfunction
	// Expected verdict; c marks the fields that the rules pin down
	function automatic void calc(input fpx_op_s o, input logic [5:0] m,
		output fpx_res_s r, output logic [11:0] c);
		logic tiny, um, mem;
		int k;
		r = '0;
		c = 12'hFD3;
		mem = 0;
		tiny = !o.overflow && o.rexp < emin(o.fmt);
		if (o.stk_under || o.stk_over || o.unsup || o.snan)
		begin
			r.raised[`FPX_IE] = 1;
			r.handler = !m[`FPX_IE];
			r.qnan_result = o.snan;
			c[3] = o.snan && m[`FPX_IE];
		end
		else if (o.qnan)
		begin
			r.qnan_result = 1;
			c[3] = 1;
		end
		else if (o.inv_other || o.div_zero)
		begin
			k = o.inv_other ? `FPX_IE : `FPX_ZE;
			r.raised[k] = 1;
			r.handler = !m[k];
		end
		else
		begin
			r.raised[`FPX_DE] = o.denorm;
			r.handler = o.denorm && !m[`FPX_DE];
		end
		c[5] = r.handler;
		if (!r.handler && !r.qnan_result && !r.raised[`FPX_IE]
			&& !r.raised[`FPX_ZE])
		begin
			k = o.overflow ? `FPX_OE : `FPX_UFLOW;
			um = !m[k];
			if (o.overflow || tiny)
			begin
				r.raised[k] = o.overflow || um || o.inexact;
				r.handler = um;
				mem = o.mem_dst && !o.simd && um;
				r.clr_cond1 = mem;
				r.denorm_result = tiny && !um;
				r.biased = um && !o.simd;
				c[2] = tiny && !um;
			end
			if (o.inexact && !mem)
			begin
				r.raised[`FPX_PREC] = 1;
				r.handler = r.handler || !m[`FPX_PREC];
			end
		end
		// SIMD keeps its destination on any unmasked fault
		r.write_dst = !c[5] && !(o.simd && r.handler);
		c[5] = 1;
	endfunction
	// Duplicated request must be refused while busy
	task automatic send(input fpx_op_s o, input bit dbl);
		fpx_res_s r;
		logic [11:0] c;
		calc(o, msk[o.simd], r, c);
		qr.push_back(r);
		qc.push_back(c);
		acc[o.simd] = acc[o.simd] | r.raised;
		op_in <= o;
		go <= 1;
		@(posedge clk);
		if (dbl) @(posedge clk);
		go <= 0;
		while (qr.size() != 0) @(posedge clk);
		repeat (2) @(posedge clk);
	endtask
	// Verdict watcher
	always @(posedge clk)
	begin
		if (resv === 1'b1 && rst_b === 1'b1)
		begin
			if (qr.size() == 0)
				check("spare verdict", 32'h1, 32'h0);
			else
			begin
				check("verdict", 32'(res & qc[0]), 32'(qr[0] & qc[0]));
				check("cond1", 32'(cond1_clr), 32'(qr[0].clr_cond1));
				void'(qr.pop_front());
				void'(qc.pop_front());
			end
		end
	end
	initial
	begin
		#400000;
		err_count++;
		print_verdict();
	end
	// Main sequence: reset values, then mask sets with random reports
	initial
	begin
		fpx_op_s o;
		logic [31:0] v;
		int k;
		repeat (6) @(posedge clk);
		rst_b <= 1;
		@(posedge clk);
		axr(`FPX_OFF_STK_STATUS, 32'h0, 2'h0);
		axr(`FPX_OFF_STK_CTRL, `FPX_RST_STK_CTRL, 2'h0);
		axr(`FPX_OFF_SIMD_CSR, `FPX_RST_SIMD_CSR, 2'h0);
		axr(12'h010, 32'h0, 2'h2);
		axw(12'h010, 32'h0, 2'h2);
		for (int p = 0; p < 4; p++)
		begin
			v = $random(seed);
			msk[0] = p == 0 ? 6'h3F : p == 1 ? 6'h00 : v[5:0];
			msk[1] = p < 2 ? msk[0] : ~v[5:0];
			acc[0] = '0;
			acc[1] = '0;
			axw(`FPX_OFF_STK_CTRL, 32'(msk[0]), 2'h0);
			axw(`FPX_OFF_SIMD_CSR, 32'(msk[1]) << 7, 2'h0);
			axw(`FPX_OFF_STK_STATUS, 32'h0, 2'h0);
			for (int i = 0; i < 40; i++)
			begin
				v = $random(seed);
				k = v[3:0] % 9;
				o = '0;
				o.simd = v[4] && k > 3;
				o.mem_dst = v[5] && !o.simd;
				o.fmt = fpx_fmt_e'(v[7:6] % 3);
				{o.stk_under, o.stk_over, o.unsup, o.snan, o.qnan, o.inv_other,
					o.div_zero, o.denorm} = k == 0 ? 8'h00 : 8'h80 >> (k - 1);
				o.rexp = 18'(emin(o.fmt) - v[8]);
				// Pair a zero divisor with other conditions now and then
				o.div_zero = o.div_zero || (v[12] && v[13]);
				o.overflow = v[9] && v[10];
				o.inexact = v[11];
				send(o, i == 5);
			end
			axr(`FPX_OFF_STK_STATUS, 32'(acc[0]), 2'h0);
			axr(`FPX_OFF_SIMD_CSR, (32'(msk[1]) << 7) | acc[1], 2'h0);
		end
		print_verdict();
	end
endmodule
